// ---- inc/bavr_pkg.sv ----
// Purpose: constants for the alternate-set buck voltage register bank
// Assumes: 32-bit APB, registers one aligned word each, 8 bits used
// Notes: printed offsets are register indices; byte address is four times the index
package bavr_pkg;
	localparam int unsigned BAVR_ADDR_W = 12;
	localparam int unsigned BAVR_REG_W = 8;
	localparam int unsigned BAVR_CODE_W = 7;
	localparam int unsigned BAVR_MV_W = 11;
	localparam int unsigned BAVR_NUM_RAILS = 3;
	// register indices as printed
	localparam logic [7:0] BAVR_IDX_CORE_TWO = 8'hB4;
	localparam logic [7:0] BAVR_IDX_CORE_ONE = 8'hB5;
	localparam logic [7:0] BAVR_IDX_PROC = 8'hB6;
	// field layout
	localparam int unsigned BAVR_SLEEP_BIT = 7;
	localparam int unsigned BAVR_CODE_MSB = 6;
	localparam int unsigned BAVR_CODE_LSB = 0;
	// reset value of every setting register
	localparam logic [7:0] BAVR_SETTING_RST = 8'h00;
	// voltage at code zero and step, in millivolts
	localparam logic [10:0] BAVR_CORE_BASE_MV = 11'h12C;
	localparam logic [10:0] BAVR_PROC_BASE_MV = 11'h212;
	localparam logic [3:0] BAVR_STEP_MV = 4'hA;
	// mode bit meaning
	localparam logic BAVR_MODE_SYNC = 1'b0;
	localparam logic BAVR_MODE_SLEEP = 1'b1;

	function automatic logic [BAVR_ADDR_W-1:0] bavr_byte_addr(input logic [7:0] idx);
		bavr_byte_addr = {2'h0, idx, 2'h0};
	endfunction : bavr_byte_addr
endpackage : bavr_pkg

// ---- inc/bavr_rail_if.sv ----
// Purpose: carries one buck's alternate setting from the bank to its rail decoder
// Assumes: same clock on both sides
// Notes: one instance per buck
interface bavr_rail_if;
	logic [7:0] setting;
	logic alt_selected;
	logic applied_valid;
	logic applied_sleep;
	logic [6:0] applied_code;
	logic [10:0] applied_mv;
	modport bank (output setting, output alt_selected, input applied_valid,
		input applied_sleep, input applied_code, input applied_mv);
	modport rail (input setting, input alt_selected, output applied_valid,
		output applied_sleep, output applied_code, output applied_mv);
endinterface : bavr_rail_if

// ---- logic/bavr_rail.sv ----
// Purpose: turns one stored alternate setting into the applied mode and voltage
// Assumes: alt_selected comes from logic on pclk
// Notes: outputs hold zero while the alternate set is not in use
module bavr_rail
	import bavr_pkg::*;
#(
	parameter logic [10:0] BASE_MV = BAVR_CORE_BASE_MV
) (
	input wire logic pclk,
	input wire logic presetn,
	bavr_rail_if.rail rail
);
	// linear code to millivolts
	function automatic logic [10:0] bavr_code_to_mv(input logic [6:0] code);
		bavr_code_to_mv = 11'(BASE_MV + 11'(code) * 11'(BAVR_STEP_MV));
	endfunction : bavr_code_to_mv

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rail.applied_valid <= 1'b0;
			rail.applied_sleep <= BAVR_MODE_SYNC;
			rail.applied_code <= 7'h00;
			rail.applied_mv <= 11'h000;
		end else if (rail.alt_selected) begin // R8
			rail.applied_valid <= 1'b1;
			rail.applied_sleep <= rail.setting[BAVR_SLEEP_BIT]; // R1 R3 R6
			rail.applied_code <= rail.setting[BAVR_CODE_MSB:BAVR_CODE_LSB];
			rail.applied_mv <= bavr_code_to_mv(rail.setting[BAVR_CODE_MSB:BAVR_CODE_LSB]); // R2 R4 R7
		end else begin
			rail.applied_valid <= 1'b0;
			rail.applied_sleep <= BAVR_MODE_SYNC;
			rail.applied_code <= 7'h00;
			rail.applied_mv <= 11'h000;
		end
	end
endmodule : bavr_rail

// ---- logic/bavr_regs.sv ----
// Purpose: APB register bank for the alternate voltage set of three bucks
// Assumes: pclk 20 MHz, presetn asynchronous active low, alt selects on pclk
// Notes: zero wait states; unmapped addresses answer pslverr and read zero
//
// Operation
// R1: Bit 7 of the register at index B4 picks synchronous (0) or sleep (1) under the B set.
// R2: Bits 6:0 of index B4 give 0.30 V at code zero plus 0.01 V per code up to 1.57 V.
// R3: Bit 7 of the register at index B5 picks synchronous (0) or sleep (1) under the B set.
// R4: Bits 6:0 of index B5 give 0.30 V at code zero plus 0.01 V per code up to 1.57 V.
// R5: Every code of both core registers lies in the forced PWM range.
// R6: Bit 7 of the register at index B6 picks synchronous (0) or sleep (1) under the B set.
// R7: Bits 6:0 of index B6 give 0.53 V at code zero plus 0.01 V per code up to 1.80 V.
// R8: A setting is applied only while its buck uses the B set, otherwise only stored.
module bavr_regs
	import bavr_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [BAVR_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic core_two_alt_select,
	input wire logic core_one_alt_select,
	input wire logic processor_alt_select,
	output logic core_two_applied_valid,
	output logic core_two_alt_sleep_select,
	output logic [6:0] core_two_alt_voltage_code,
	output logic [10:0] core_two_applied_mv,
	output logic core_two_pwm_range_ok,
	output logic core_one_applied_valid,
	output logic core_one_alt_sleep_select,
	output logic [6:0] core_one_alt_voltage_code,
	output logic [10:0] core_one_applied_mv,
	output logic core_one_pwm_range_ok,
	output logic processor_applied_valid,
	output logic processor_alt_sleep_select,
	output logic [6:0] processor_alt_voltage_code,
	output logic [10:0] processor_applied_mv
);
	logic [7:0] core_two_alt_setting_reg;
	logic [7:0] core_one_alt_setting_reg;
	logic [7:0] processor_alt_setting_reg;
	logic access;
	logic hit_core_two;
	logic hit_core_one;
	logic hit_proc;
	logic mapped;
	logic wr_en;
	logic [31:0] prdata_next;

	bavr_rail_if core_two_if ();
	bavr_rail_if core_one_if ();
	bavr_rail_if proc_if ();

	assign access = psel & penable;
	assign hit_core_two = (paddr == bavr_byte_addr(BAVR_IDX_CORE_TWO));
	assign hit_core_one = (paddr == bavr_byte_addr(BAVR_IDX_CORE_ONE));
	assign hit_proc = (paddr == bavr_byte_addr(BAVR_IDX_PROC));
	assign mapped = hit_core_two | hit_core_one | hit_proc;
	// only the low byte lane carries register data
	assign wr_en = access & pwrite & mapped & pstrb[0];
	assign pready = 1'b1;
	assign pslverr = access & ~mapped;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_two_alt_setting_reg <= BAVR_SETTING_RST;
		end else if (wr_en && hit_core_two) begin
			core_two_alt_setting_reg <= pwdata[7:0]; // R1 R2
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_one_alt_setting_reg <= BAVR_SETTING_RST;
		end else if (wr_en && hit_core_one) begin
			core_one_alt_setting_reg <= pwdata[7:0]; // R3 R4
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			processor_alt_setting_reg <= BAVR_SETTING_RST;
		end else if (wr_en && hit_proc) begin
			processor_alt_setting_reg <= pwdata[7:0]; // R6 R7
		end
	end

	// read data captured at the setup edge, held through the access phase
	always_comb begin
		prdata_next = 32'h0000_0000;
		if (hit_core_two) begin
			prdata_next = {24'h00_0000, core_two_alt_setting_reg};
		end else if (hit_core_one) begin
			prdata_next = {24'h00_0000, core_one_alt_setting_reg};
		end else if (hit_proc) begin
			prdata_next = {24'h00_0000, processor_alt_setting_reg};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= prdata_next;
		end
	end

	assign core_two_if.setting = core_two_alt_setting_reg;
	assign core_two_if.alt_selected = core_two_alt_select; // R8
	assign core_one_if.setting = core_one_alt_setting_reg;
	assign core_one_if.alt_selected = core_one_alt_select; // R8
	assign proc_if.setting = processor_alt_setting_reg;
	assign proc_if.alt_selected = processor_alt_select; // R8

	bavr_rail #(.BASE_MV(BAVR_CORE_BASE_MV)) u_core_two (
		.pclk(pclk),
		.presetn(presetn),
		.rail(core_two_if)
	);

	bavr_rail #(.BASE_MV(BAVR_CORE_BASE_MV)) u_core_one (
		.pclk(pclk),
		.presetn(presetn),
		.rail(core_one_if)
	);

	bavr_rail #(.BASE_MV(BAVR_PROC_BASE_MV)) u_proc (
		.pclk(pclk),
		.presetn(presetn),
		.rail(proc_if)
	);

	assign core_two_applied_valid = core_two_if.applied_valid;
	assign core_two_alt_sleep_select = core_two_if.applied_sleep;
	assign core_two_alt_voltage_code = core_two_if.applied_code;
	assign core_two_applied_mv = core_two_if.applied_mv;
	// full code span is usable in forced PWM
	assign core_two_pwm_range_ok = core_two_if.applied_valid; // R5
	assign core_one_applied_valid = core_one_if.applied_valid;
	assign core_one_alt_sleep_select = core_one_if.applied_sleep;
	assign core_one_alt_voltage_code = core_one_if.applied_code;
	assign core_one_applied_mv = core_one_if.applied_mv;
	assign core_one_pwm_range_ok = core_one_if.applied_valid; // R5
	assign processor_applied_valid = proc_if.applied_valid;
	assign processor_alt_sleep_select = proc_if.applied_sleep;
	assign processor_alt_voltage_code = proc_if.applied_code;
	assign processor_applied_mv = proc_if.applied_mv;
endmodule : bavr_regs

// ---- testbench/bavr_regs_chk.sv ----
// Purpose: port checker for the alternate-set buck register bank
// Assumes: one clock, zero-wait APB
// Notes: bound to every bavr_regs
module bavr_regs_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [11:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic core_two_alt_select,
	input wire logic core_two_applied_valid,
	input wire logic [6:0] core_two_alt_voltage_code,
	input wire logic [10:0] core_two_applied_mv,
	input wire logic core_two_pwm_range_ok,
	input wire logic core_one_applied_valid,
	input wire logic [6:0] core_one_alt_voltage_code,
	input wire logic [10:0] core_one_applied_mv,
	input wire logic core_one_pwm_range_ok,
	input wire logic processor_alt_select,
	input wire logic processor_alt_sleep_select,
	input wire logic processor_applied_valid,
	input wire logic [6:0] processor_alt_voltage_code,
	input wire logic [10:0] processor_applied_mv
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence setup_s;
		psel && !penable ##1 psel && penable;
	endsequence
	sequence bad_access_s;
		psel && penable && (paddr < 12'h2D0 || paddr > 12'h2D8);
	endsequence
	chk_zero_wait: assert property (setup_s |-> pready)
		else $error("access phase not ready");
	chk_bad_addr: assert property (bad_access_s |-> pslverr)
		else $error("unmapped access without error");
	chk_core_two_mv: assert property (core_two_applied_valid |->
		core_two_applied_mv == 11'h12C + 11'h00A * core_two_alt_voltage_code)
		else $error("core two voltage wrong");
	chk_core_one_mv: assert property (core_one_applied_valid |->
		core_one_applied_mv == 11'h12C + 11'h00A * core_one_alt_voltage_code)
		else $error("core one voltage wrong");
	chk_proc_mv: assert property (processor_applied_valid |->
		processor_applied_mv == 11'h212 + 11'h00A * processor_alt_voltage_code)
		else $error("processor voltage wrong");
	chk_pwm_range: assert property (core_two_pwm_range_ok == core_two_applied_valid &&
		core_one_pwm_range_ok == core_one_applied_valid)
		else $error("pwm range flag wrong");
	chk_core_two_apply: assert property (core_two_alt_select |=> core_two_applied_valid)
		else $error("core two setting not applied");
	chk_proc_release: assert property (!processor_alt_select |=>
		!processor_applied_valid && !processor_alt_sleep_select && processor_applied_mv == 11'h000)
		else $error("processor output not cleared");
endmodule : bavr_regs_chk

bind bavr_regs bavr_regs_chk bavr_regs_chk_inst (.*);

// ---- testbench/bavr_regs_bench.sv ----
// Purpose: self-checking bench for the alternate-set buck register bank
// Assumes: zero-wait APB, rail outputs one edge after a change
// Notes: a monitor checks results against a queue of notes
module bavr_regs_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rq = 0, pready, pslverr;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [3:0] pstrb = 4'h0;
	logic [2:0] sel = 3'h0;
	logic [7:0] pat [4] = '{8'h00, 8'hFF, 8'h80, 8'h5A};
	logic [32:0] q[$];
	wire [20:0] r0, r1, r2;
	int bad_count = 0, checked = 0, cyc = 0, ri = 0, seed = 32'h0EF9;
	bavr_regs bavr_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .core_two_alt_select(sel[0]),
		.core_one_alt_select(sel[1]), .processor_alt_select(sel[2]),
		.core_two_applied_valid(r0[19]), .core_two_alt_sleep_select(r0[18]),
		.core_two_alt_voltage_code(r0[17:11]), .core_two_applied_mv(r0[10:0]),
		.core_two_pwm_range_ok(r0[20]), .core_one_applied_valid(r1[19]),
		.core_one_alt_sleep_select(r1[18]), .core_one_alt_voltage_code(r1[17:11]),
		.core_one_applied_mv(r1[10:0]), .core_one_pwm_range_ok(r1[20]),
		.processor_applied_valid(r2[19]), .processor_alt_sleep_select(r2[18]),
		.processor_alt_voltage_code(r2[17:11]), .processor_applied_mv(r2[10:0]));
	// processor rail has no pwm range flag
	assign r2[20] = 1'b0;
	always #25 pclk = ~pclk;
	task report_and_stop;
		if (q.size() != 0) bad_count++;
		$display("checks %0d errors %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : report_and_stop
	task cmp(input string nm, input logic [32:0] got);
		logic [32:0] e;
		e = q.size() ? q.pop_front() : 33'h1FFFFFFFF;
		checked++;
		if (got !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, e, got);
		end
	endtask : cmp
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite) cmp("prdata", {pslverr, prdata});
		if (rq) cmp("rail", {12'h0, ri == 0 ? r0 : ri == 1 ? r1 : r2});
		cyc++;
		if (cyc == 2000) begin
			bad_count++;
			report_and_stop;
		end
	end
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'h2, w, a, d, s};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		{psel, penable} <= 2'h0;
	endtask : apb
	task wr(input logic [11:0] a, input logic [7:0] v);
		logic [31:0] d;
		d = $random(seed);
		d[7:0] = v;
		apb(1'b1, a, d, 4'hF);
	endtask : wr
	task rd(input logic [11:0] a, input logic [32:0] e);
		q.push_back(e);
		apb(1'b0, a, $random(seed), 4'h0);
	endtask : rd
	task rchk(input int i, input logic [7:0] v, input logic on);
		logic [10:0] mv;
		mv = 11'(v[6:0] * 11'h00A + (i == 2 ? 11'h212 : 11'h12C));
		@(posedge pclk);
		q.push_back(on ? {12'h0, i != 2, 1'b1, v, mv} : 33'h0);
		ri <= i;
		rq <= 1'b1;
		@(posedge pclk);
		rq <= 1'b0;
	endtask : rchk
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		sel <= 3'h7;
		pat[3] = 8'($random(seed));
		for (int i = 0; i < 3; i++) begin
			rd(12'h2D0 + 12'(4 * i), 33'h0);
			foreach (pat[k]) begin
				wr(12'h2D0 + 12'(4 * i), pat[k]);
				rchk(i, pat[k], 1'b1);
				apb(1'b1, 12'h2D0 + 12'(4 * i), ~{24'h0, pat[k]}, 4'hE);
				rd(12'h2D0 + 12'(4 * i), {25'h0, pat[k]});
			end
		end
		wr(12'h2DC, 8'hFF);
		rd(12'h2DC, {1'b1, 32'h0});
		@(posedge pclk);
		sel <= 3'h0;
		for (int i = 0; i < 3; i++) rchk(i, 8'h00, 1'b0);
		wr(12'h2D8, 8'hC3);
		rd(12'h2D8, 33'h0C3);
		rchk(2, 8'h00, 1'b0);
		sel <= 3'h4;
		rchk(2, 8'hC3, 1'b1);
		rchk(0, 8'h00, 1'b0);
		// reset in mid-run clears the stored settings
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		rd(12'h2D8, 33'h0);
		rchk(2, 8'h00, 1'b1);
		repeat (2) @(posedge pclk);
		report_and_stop;
	end
endmodule : bavr_regs_bench
